// [rtl/dhpc_core.sv]
`timescale 1ns/1ps
module dhpc_core
  import dhpc_pkg::*;
#(
  parameter int unsigned P_STEP_UNIT_CYCLES = STEP_UNIT_CYC,
  parameter int unsigned P_BYTE_CYCLES = BYTE_CYC
)
(
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic [2:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [NUM_DRIVES-1:0] i_track_zero_sense,
  input wire logic [NUM_DRIVES-1:0] i_drive_ready,
  input wire logic i_index_pulse_input,
  input wire logic i_id_valid,
  input wire dhpc_id_field_t i_id_field,
  output logic [NUM_DRIVES-1:0] o_step,
  output logic [NUM_DRIVES-1:0] o_dir,
  output logic [1:0] o_drive_sel,
  output logic o_head_select_bit,
  output logic o_int,
  output logic [7:0] o_wr_byte,
  output logic o_wr_strobe
);

  typedef struct packed {
    logic wreq;
    logic [31:0] rdata;
    dhpc_phase_t phase;
    logic [7:0] op;
    logic pcount;
    logic [1:0] drv;
    logic head;
    logic [6:0][7:0] res;
    logic [2:0] ridx;
    logic [2:0] rlen;
    logic idx_cnt;
    logic [3:0] step_interval_setting;
    logic low_power;
    logic dens;
    dhpc_pre_t pre;
    logic [6:0] pre_cnt;
    logic [7:0] wr_byte;
    logic wr_stb;
    logic [DIV_W-1:0] ms_div;
    logic [DIV_W-1:0] byte_div;
    logic ms_tick;
    logic [NUM_DRIVES-1:0] int_pend;
    logic [NUM_DRIVES-1:0][7:0] st0s;
    logic rid_int;
    logic int_line;
    logic [NUM_DRIVES-1:0] trk_s1;
    logic [NUM_DRIVES-1:0] trk_s2;
    logic [NUM_DRIVES-1:0] rdy_s1;
    logic [NUM_DRIVES-1:0] rdy_s2;
    logic idx_s1;
    logic idx_s2;
    logic idx_prev;
    logic [NUM_DRIVES-1:0] start_recal;
    logic [NUM_DRIVES-1:0] start_seek;
    logic [7:0] target;
    logic clear_pos;
  } dhpc_core_state_t;

  dhpc_core_state_t s;
  dhpc_core_state_t next_s;
  logic [NUM_DRIVES-1:0] pos_busy;
  logic [NUM_DRIVES-1:0][7:0] present_cylinder_count;
  dhpc_pos_report_t [NUM_DRIVES-1:0] rpt;

  // ----------------------------------------
  // Per-drive positioners
  // ----------------------------------------
  genvar gd;
  generate
    for (gd = 0; gd < NUM_DRIVES; gd++)
    begin : g_drive
      dhpc_positioner u_pos (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_tick(s.ms_tick),
        .i_step_interval_setting(s.step_interval_setting),
        .i_start_recal(s.start_recal[gd]),
        .i_start_seek(s.start_seek[gd]),
        .i_target_cylinder(s.target),
        .i_clear(s.clear_pos),
        .i_track_zero_sense(s.trk_s2[gd]),
        .i_ready(s.rdy_s2[gd]),
        .o_step(o_step[gd]),
        .o_dir(o_dir[gd]),
        .o_busy(pos_busy[gd]),
        .o_present_cylinder_count(present_cylinder_count[gd]),
        .o_report(rpt[gd])
      );
    end
  endgenerate

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic [4:0] byte_addr;
  logic rd_fire;
  logic wr_fire;
  logic idx_rise;
  logic found;
  logic [7:0] wd;
  logic [6:0] gap_len;
  logic [6:0] sync_len;

  always_comb
  begin
    next_s = s;
    byte_addr = {i_avs_address, 2'b00};
    rd_fire = i_avs_read && !s.wreq;
    wr_fire = i_avs_write && !s.wreq;
    idx_rise = s.idx_s2 && !s.idx_prev;
    found = 1'b0;
    wd = i_avs_writedata[7:0];
    gap_len = s.dens ? MFM_GAP_LEN : FM_GAP_LEN;
    sync_len = s.dens ? MFM_SYNC_LEN : FM_SYNC_LEN;
    next_s.start_recal = '0;
    next_s.start_seek = '0;
    next_s.clear_pos = 1'b0;
    next_s.wr_stb = 1'b0;
    next_s.ms_tick = 1'b0;

    // Pin synchronisers
    next_s.trk_s1 = i_track_zero_sense;
    next_s.trk_s2 = s.trk_s1;
    next_s.rdy_s1 = i_drive_ready;
    next_s.rdy_s2 = s.rdy_s1;
    next_s.idx_s1 = i_index_pulse_input;
    next_s.idx_s2 = s.idx_s1;
    next_s.idx_prev = s.idx_s2;

    // Step interval time base
    next_s.ms_div = s.ms_div + 1'b1;
    if (s.ms_div == DIV_W'(P_STEP_UNIT_CYCLES - 1))
    begin
      next_s.ms_div = '0;
      next_s.ms_tick = 1'b1;
    end

    // Bus: one wait cycle, then answer
    next_s.wreq = !((i_avs_read || i_avs_write) && s.wreq);
    if (i_avs_read && s.wreq)
    begin
      next_s.rdata = '0;
      case (byte_addr)
        OFF_DATA:
          if (s.phase == PH_RESULT)
            next_s.rdata[7:0] = s.res[s.ridx];
        OFF_MAIN_STATUS:
        begin
          next_s.rdata[MS_REQ_READY] = (s.phase != PH_READID);
          next_s.rdata[MS_TO_HOST] = (s.phase == PH_RESULT);
          next_s.rdata[MS_BUSY] = (s.phase != PH_IDLE);
          next_s.rdata[NUM_DRIVES-1:0] = pos_busy;
        end
        OFF_CONTROL:
          next_s.rdata[7:0] = {2'b00, s.dens, s.low_power, s.step_interval_setting};
        OFF_CYLINDERS:
          next_s.rdata = {present_cylinder_count[3], present_cylinder_count[2], present_cylinder_count[1], present_cylinder_count[0]};
        OFF_INT_STATUS:
          next_s.rdata[7:0] = {s.int_pend, 3'b000, s.int_line};
        default:
          next_s.rdata = '0;
      endcase
    end

    if (wr_fire && byte_addr == OFF_CONTROL)
    begin
      next_s.step_interval_setting = i_avs_writedata[CTRL_SRT_LSB +: 4];
      next_s.low_power = i_avs_writedata[CTRL_LOW_POWER];
      next_s.dens = i_avs_writedata[CTRL_DENSITY];
      if (i_avs_writedata[CTRL_PRE_GO] && s.pre == PRE_IDLE)
        next_s.pre = PRE_WAIT_IDX;
      if (s.low_power && !i_avs_writedata[CTRL_LOW_POWER])
      begin
        next_s.clear_pos = 1'b1;
        next_s.st0s = '0;
        next_s.int_pend = '0;
      end
    end

    // ----------------------------------------
    // Command, execution and result phases
    // ----------------------------------------
    // only command and result bytes
    case (s.phase)
      PH_IDLE:
        if (wr_fire && byte_addr == OFF_DATA)
        begin
          next_s.op = wd;
          next_s.pcount = 1'b0;
          next_s.ridx = '0;
          next_s.phase = PH_RESULT;
          next_s.rlen = 3'h1;
          next_s.res[0] = {IC_INVALID, 6'h00};
          if ((wd & OPC_READID_MASK) == OPC_READID || wd == OPC_RECAL || wd == OPC_SEEK)
            next_s.phase = PH_PARAM;
          else if (wd == OPC_SENSE_INT)
          begin
            for (int d = 0; d < NUM_DRIVES; d++)
            begin
              if (s.int_pend[d] && !found)
              begin
                found = 1'b1;
                next_s.res[0] = s.st0s[d];
                next_s.res[1] = present_cylinder_count[d];
                next_s.rlen = 3'h2;
                next_s.int_pend[d] = 1'b0;
              end
            end
          end
        end
      PH_PARAM:
        if (wr_fire && byte_addr == OFF_DATA)
        begin
          if (!s.pcount)
          begin
            next_s.drv = wd[1:0];
            next_s.head = wd[2];
          end
          if (s.op == OPC_SEEK && !s.pcount)
            next_s.pcount = 1'b1;
          else if (s.op == OPC_SEEK)
          begin
            next_s.target = wd;
            next_s.start_seek[s.drv] = 1'b1;
            next_s.phase = PH_IDLE;
          end
          else if (s.op == OPC_RECAL)
          begin
            next_s.start_recal[wd[1:0]] = 1'b1;
            next_s.phase = PH_IDLE;
          end
          else
          begin
            next_s.idx_cnt = 1'b0;
            next_s.phase = PH_READID;
          end
        end
      PH_READID:
      begin
        next_s.ridx = '0;
        next_s.rlen = READID_RES_LEN;
        // Stale id bytes must not leak into a missed-mark result
        next_s.res[6:2] = '0;
        if (i_id_valid)
        begin
          next_s.res[0] = {IC_NORMAL, 3'b000, s.head, s.drv};
          next_s.res[1] = '0;
          next_s.res[3] = i_id_field.cyl;
          next_s.res[4] = i_id_field.head;
          next_s.res[5] = i_id_field.sector;
          next_s.res[6] = i_id_field.size;
          next_s.rid_int = 1'b1;
          next_s.phase = PH_RESULT;
        end
        else if (idx_rise)
        begin
          next_s.idx_cnt = 1'b1;
          if (s.idx_cnt)
          begin
            next_s.res[0] = {IC_ABNORMAL, 3'b000, s.head, s.drv};
            next_s.res[1] = ST1_MISSING_MARK;
            next_s.rid_int = 1'b1;
            next_s.phase = PH_RESULT;
          end
        end
      end
      PH_RESULT:
        if (rd_fire && byte_addr == OFF_DATA)
        begin
          next_s.ridx = s.ridx + 1'b1;
          if (s.ridx == s.rlen - 3'h1)
          begin
            next_s.phase = PH_IDLE;
            next_s.rid_int = 1'b0;
          end
        end
      default:
        next_s.phase = PH_IDLE;
    endcase

    // Completions after clears so a same-cycle end is kept
    for (int d = 0; d < NUM_DRIVES; d++)
    begin
      if (rpt[d].done)
      begin
        next_s.int_pend[d] = 1'b1;
        next_s.st0s[d] = {1'b0, rpt[d].abnormal, 1'b1, rpt[d].equip_check,
                          rpt[d].not_ready, 1'b0, 2'(d)};
      end
    end
    next_s.int_line = (|next_s.int_pend) || next_s.rid_int;

    // ----------------------------------------
    // Track preamble writer
    // ----------------------------------------
    next_s.byte_div = s.byte_div + 1'b1;
    if (s.pre == PRE_IDLE || s.pre == PRE_WAIT_IDX)
      next_s.byte_div = '0;
    case (s.pre)
      PRE_IDLE:
        next_s.pre_cnt = '0;
      PRE_WAIT_IDX:
        if (idx_rise)
          next_s.pre = PRE_GAP;
      default:
        if (s.byte_div == DIV_W'(P_BYTE_CYCLES - 1))
        begin
          next_s.byte_div = '0;
          next_s.wr_stb = 1'b1;
          next_s.pre_cnt = s.pre_cnt + 1'b1;
          case (s.pre)
            PRE_GAP:
            begin
              next_s.wr_byte = s.dens ? GAP_BYTE_MFM : GAP_BYTE_FM;
              if (s.pre_cnt == gap_len - 7'h01)
              begin
                next_s.pre_cnt = '0;
                next_s.pre = PRE_SYNC;
              end
            end
            PRE_SYNC:
            begin
              next_s.wr_byte = SYNC_BYTE;
              if (s.pre_cnt == sync_len - 7'h01)
              begin
                next_s.pre_cnt = '0;
                next_s.pre = s.dens ? PRE_MARK : PRE_IAM;
              end
            end
            PRE_MARK:
            begin
              next_s.wr_byte = MARK_PREFIX_MFM;
              if (s.pre_cnt == MFM_MARK_LEN - 7'h01)
                next_s.pre = PRE_IAM;
            end
            default:
            begin
              next_s.wr_byte = INDEX_MARK_BYTE;
              next_s.pre = PRE_IDLE;
            end
          endcase
        end
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      s <= '0;
      s.wreq <= 1'b1;
      s.step_interval_setting <= CTRL_SRT_RESET;
    end
    else
      s <= next_s;
  end

  assign o_avs_readdata = s.rdata;
  assign o_avs_waitrequest = s.wreq;
  assign o_drive_sel = s.drv;
  assign o_head_select_bit = s.head;
  assign o_int = s.int_line;
  assign o_wr_byte = s.wr_byte;
  assign o_wr_strobe = s.wr_stb;

endmodule

// [include/dhpc_pkg.sv]
package dhpc_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int CLK_PERIOD_NS = 10;
  localparam int STEP_UNIT_US = 1000;
  localparam int STEP_UNIT_CYC = STEP_UNIT_US * CLK_MHZ;
  localparam int STEP_WIDTH_NS = 1000;
  localparam int STEP_WIDTH_CYC = (STEP_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BYTE_TIME_NS = 16000;
  localparam int BYTE_CYC = BYTE_TIME_NS / CLK_PERIOD_NS;
  localparam int DIV_W = 17;
  localparam int NUM_DRIVES = 4;
  localparam logic [7:0] RECAL_MAX_STEPS = 8'hFF;
  localparam logic [4:0] STEP_INTERVAL_BASE = 5'h10;

  // ----------------------------------------
  // Register map, byte offsets
  // ----------------------------------------
  localparam logic [4:0] OFF_DATA = 5'h00;
  localparam logic [4:0] OFF_MAIN_STATUS = 5'h04;
  localparam logic [4:0] OFF_CONTROL = 5'h08;
  localparam logic [4:0] OFF_CYLINDERS = 5'h0C;
  localparam logic [4:0] OFF_INT_STATUS = 5'h10;
  localparam int MS_REQ_READY = 7;
  localparam int MS_TO_HOST = 6;
  localparam int MS_BUSY = 4;
  localparam int CTRL_SRT_LSB = 0;
  localparam int CTRL_LOW_POWER = 4;
  localparam int CTRL_DENSITY = 5;
  localparam int CTRL_PRE_GO = 6;
  localparam logic [3:0] CTRL_SRT_RESET = 4'h0;

  // ----------------------------------------
  // Commands and status bytes
  // ----------------------------------------
  localparam logic [7:0] OPC_READID = 8'h0A;
  localparam logic [7:0] OPC_READID_MASK = 8'hBF;
  localparam logic [7:0] OPC_RECAL = 8'h07;
  localparam logic [7:0] OPC_SEEK = 8'h0F;
  localparam logic [7:0] OPC_SENSE_INT = 8'h08;
  localparam int OPC_DENSITY_BIT = 6;
  localparam logic [1:0] IC_NORMAL = 2'h0;
  localparam logic [1:0] IC_ABNORMAL = 2'h1;
  localparam logic [1:0] IC_INVALID = 2'h2;
  localparam logic [7:0] ST1_MISSING_MARK = 8'h01;
  localparam logic [2:0] READID_RES_LEN = 3'h7;

  // ----------------------------------------
  // Track preamble layout
  // ----------------------------------------
  localparam logic [6:0] MFM_GAP_LEN = 7'h50;
  localparam logic [6:0] MFM_SYNC_LEN = 7'h0C;
  localparam logic [6:0] MFM_MARK_LEN = 7'h03;
  localparam logic [6:0] FM_GAP_LEN = 7'h28;
  localparam logic [6:0] FM_SYNC_LEN = 7'h06;
  localparam logic [7:0] GAP_BYTE_MFM = 8'h4E;
  localparam logic [7:0] GAP_BYTE_FM = 8'hFF;
  localparam logic [7:0] SYNC_BYTE = 8'h00;
  localparam logic [7:0] MARK_PREFIX_MFM = 8'hC2;
  localparam logic [7:0] INDEX_MARK_BYTE = 8'hFC;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] cyl;
    logic [7:0] head;
    logic [7:0] sector;
    logic [7:0] size;
  } dhpc_id_field_t;

  typedef struct packed {
    logic done;
    logic abnormal;
    logic equip_check;
    logic not_ready;
  } dhpc_pos_report_t;

  typedef enum logic [1:0] {PH_IDLE, PH_PARAM, PH_READID, PH_RESULT} dhpc_phase_t;
  typedef enum logic [2:0] {PRE_IDLE, PRE_WAIT_IDX, PRE_GAP, PRE_SYNC, PRE_MARK, PRE_IAM}
    dhpc_pre_t;
  typedef enum logic [1:0] {POS_IDLE, POS_CHECK, POS_PULSE, POS_WAIT} dhpc_pos_st_t;

endpackage

// [rtl/dhpc_positioner.sv]
`timescale 1ns/1ps
module dhpc_positioner
  import dhpc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_tick,
  input wire logic [3:0] i_step_interval_setting,
  input wire logic i_start_recal,
  input wire logic i_start_seek,
  input wire logic [7:0] i_target_cylinder,
  input wire logic i_clear,
  input wire logic i_track_zero_sense,
  input wire logic i_ready,
  output logic o_step,
  output logic o_dir,
  output logic o_busy,
  output logic [7:0] o_present_cylinder_count,
  output dhpc_pos_report_t o_report
);

  typedef struct packed {
    dhpc_pos_st_t st;
    logic recal;
    logic dir;
    logic step;
    logic [7:0] present_cylinder_count;
    logic [7:0] target;
    logic [7:0] steps;
    logic [DIV_W-1:0] cnt;
    dhpc_pos_report_t rpt;
  } dhpc_pos_state_t;

  dhpc_pos_state_t s;
  dhpc_pos_state_t next_s;
  logic [4:0] interval;

  always_comb
  begin
    next_s = s;
    next_s.rpt = '0;
    interval = STEP_INTERVAL_BASE - {1'b0, i_step_interval_setting};
    case (s.st)
      POS_IDLE:
      begin
        if (i_start_recal)
        begin
          next_s.present_cylinder_count = '0;
          next_s.steps = '0;
          next_s.recal = 1'b1;
          next_s.dir = 1'b0;
          next_s.st = POS_CHECK;
        end
        else if (i_start_seek)
        begin
          next_s.target = i_target_cylinder;
          next_s.recal = 1'b0;
          next_s.st = POS_CHECK;
        end
      end
      POS_CHECK:
      begin
        next_s.cnt = '0;
        next_s.st = POS_PULSE;
        if (!i_ready)
        begin
          next_s.rpt = '{done: 1'b1, abnormal: 1'b1, equip_check: 1'b0, not_ready: 1'b1};
          next_s.st = POS_IDLE;
        end
        else if (s.recal)
        begin
          if (i_track_zero_sense)
          begin
            next_s.rpt.done = 1'b1;
            next_s.st = POS_IDLE;
          end
          else if (s.steps == RECAL_MAX_STEPS)
          begin
            next_s.rpt = '{done: 1'b1, abnormal: 1'b1, equip_check: 1'b1, not_ready: 1'b0};
            next_s.st = POS_IDLE;
          end
          else
          begin
            next_s.dir = 1'b0;
            next_s.step = 1'b1;
          end
        end
        else if (s.present_cylinder_count == s.target)
        begin
          next_s.rpt.done = 1'b1;
          next_s.st = POS_IDLE;
        end
        else
        begin
          next_s.dir = (s.present_cylinder_count < s.target);
          next_s.step = 1'b1;
        end
      end
      POS_PULSE:
      begin
        next_s.cnt = s.cnt + 1'b1;
        if (s.cnt == DIV_W'(STEP_WIDTH_CYC - 1))
        begin
          next_s.step = 1'b0;
          next_s.cnt = '0;
          next_s.st = POS_WAIT;
          if (s.recal)
            next_s.steps = s.steps + 1'b1;
          else if (s.dir)
            next_s.present_cylinder_count = s.present_cylinder_count + 1'b1;
          else
            next_s.present_cylinder_count = s.present_cylinder_count - 1'b1;
        end
      end
      POS_WAIT:
      begin
        if (i_tick)
        begin
          next_s.cnt = s.cnt + 1'b1;
          if (s.cnt[4:0] == interval - 5'h01)
            next_s.st = POS_CHECK;
        end
      end
      default:
        next_s.st = POS_IDLE;
    endcase
    if (i_clear)
      next_s.present_cylinder_count = '0;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
      s <= '0;
    else
      s <= next_s;
  end

  assign o_step = s.step;
  assign o_dir = s.dir;
  assign o_busy = (s.st != POS_IDLE);
  assign o_present_cylinder_count = s.present_cylinder_count;
  assign o_report = s.rpt;

endmodule

// [sim/dhpc_core_properties.sv]
`timescale 1ns/1ps
module dhpc_core_properties
  import dhpc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic [NUM_DRIVES-1:0] o_step,
  input wire logic [NUM_DRIVES-1:0] o_dir,
  input wire logic o_wr_strobe
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);
  property p_wait_answer;
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer)
    else $error("bus request not answered");
  property p_wait_rest;
    !(i_avs_read || i_avs_write) && o_avs_waitrequest |=> o_avs_waitrequest;
  endproperty
  a_wait_rest: assert property (p_wait_rest)
    else $error("answer without request");
  property p_wait_one;
    !o_avs_waitrequest |=> o_avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("answer longer than one cycle");
  property p_step_w0;
    $rose(o_step[0]) |-> ##99 o_step[0] ##1 !o_step[0];
  endproperty
  a_step_w0: assert property (p_step_w0)
    else $error("drive 0 step width wrong");
  property p_step_w3;
    $rose(o_step[3]) |-> ##99 o_step[3] ##1 !o_step[3];
  endproperty
  a_step_w3: assert property (p_step_w3)
    else $error("drive 3 step width wrong");
  property p_dir_hold;
    o_step[1] && $past(o_step[1]) |-> $stable(o_dir[1]);
  endproperty
  a_dir_hold: assert property (p_dir_hold)
    else $error("direction moved during step");
  property p_step_gap;
    $fell(o_step[0]) |-> !o_step[0] [*8];
  endproperty
  a_step_gap: assert property (p_step_gap)
    else $error("steps too close");
  property p_strobe;
    o_wr_strobe |=> !o_wr_strobe [*3];
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("preamble bytes too close");
endmodule

bind dhpc_core dhpc_core_properties u_dhpc_core_properties (
  .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
  .o_step(o_step), .o_dir(o_dir), .o_wr_strobe(o_wr_strobe));

// [sim/dhpc_drive_model.sv]
`timescale 1ns/1ps
module dhpc_drive_model
  import dhpc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic [NUM_DRIVES-1:0] i_step,
  input wire logic [NUM_DRIVES-1:0] i_dir,
  output logic [NUM_DRIVES-1:0] o_track_zero_sense
);
  // Drive 3 starts too far out to reach zero in one pass
  int pos [NUM_DRIVES] = '{2, 5, 8, 300};
  logic [NUM_DRIVES-1:0] last_step = '0;
  always @(posedge i_ref_clk)
  begin
    last_step <= i_step;
    for (int d = 0; d < NUM_DRIVES; d++)
      if (i_step[d] && !last_step[d])
        pos[d] <= i_dir[d] ? pos[d] + 1 : (pos[d] > 0 ? pos[d] - 1 : 0);
  end
  always_comb
    for (int d = 0; d < NUM_DRIVES; d++)
      o_track_zero_sense[d] = (pos[d] == 0);
endmodule

// [sim/tb.sv]
`timescale 1ns/1ps
module tb;
  import dhpc_pkg::*;
  logic i_ref_clk = 0;
  logic i_nrst = 0;
  logic [2:0] addr = '0;
  logic rd = 0;
  logic wr = 0;
  logic [31:0] wd = '0;
  logic [31:0] rdata;
  logic wreq;
  logic [3:0] tz;
  logic [3:0] rdy = 4'hF;
  logic idx = 0;
  logic idv = 0;
  dhpc_id_field_t idf = '0;
  logic [3:0] stp;
  logic [3:0] dir;
  logic [7:0] wbyte;
  logic wstb;
  logic irq;
  logic [1:0] dsel;
  logic hsel;
  logic [31:0] q[$];
  int n_mismatch = 0;
  int n_checks = 0;
  logic [7:0] t;
  always #5 i_ref_clk = ~i_ref_clk;
  dhpc_core #(.P_STEP_UNIT_CYCLES(20), .P_BYTE_CYCLES(4)) u_dhpc_core (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_track_zero_sense(tz), .i_drive_ready(rdy),
    .i_index_pulse_input(idx), .i_id_valid(idv), .i_id_field(idf), .o_step(stp),
    .o_dir(dir), .o_drive_sel(dsel), .o_head_select_bit(hsel), .o_int(irq),
    .o_wr_byte(wbyte), .o_wr_strobe(wstb));
  dhpc_drive_model u_dhpc_drive_model (
    .i_ref_clk(i_ref_clk), .i_step(stp), .i_dir(dir), .o_track_zero_sense(tz));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Read expectations ride in d; the monitor compares them
  task automatic bus(input logic [2:0] a, input logic w, input logic [31:0] d);
    addr <= a;
    rd <= !w;
    wr <= w;
    wd <= d;
    if (!w)
      q.push_back(d);
    do @(posedge i_ref_clk); while (wreq !== 1'b0);
    rd <= 0;
    wr <= 0;
    @(posedge i_ref_clk);
  endtask
  task automatic wait_int();
    for (int k = 0; k < 50000 && irq !== 1'b1; k++)
      @(posedge i_ref_clk);
  endtask
  task automatic sense(input logic [7:0] s, input logic [7:0] c);
    wait_int();
    bus(0, 1, 32'h0000_0008);
    bus(0, 0, {24'h00_0000, s});
    bus(0, 0, {24'h00_0000, c});
  endtask
  task automatic pulse_idx();
    idx <= 1;
    repeat (4) @(posedge i_ref_clk);
    idx <= 0;
    repeat (4) @(posedge i_ref_clk);
  endtask
  task automatic preamble(input logic [7:0] g, input int ng, input int ns, input int nm,
                          input logic [31:0] ctl);
    repeat (ng) q.push_back({24'h00_0000, g});
    repeat (ns) q.push_back(32'h0000_0000);
    repeat (nm) q.push_back(32'h0000_00C2);
    q.push_back(32'h0000_00FC);
    bus(2, 1, ctl);
    pulse_idx();
    for (int k = 0; k < 2000 && q.size() > 0; k++)
      @(posedge i_ref_clk);
    repeat (20) @(posedge i_ref_clk);
  endtask
  always @(posedge i_ref_clk)
    if (i_nrst && ((rd && !wreq) || wstb))
      chk(wstb ? {24'h00_0000, wbyte} : rdata, q.size() ? q.pop_front() : 32'hxxxx_xxxx);
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #800000;
    n_mismatch++;
    complete_run();
  end
  initial
  begin
    void'($urandom(77));
    repeat (2) @(posedge i_ref_clk);
    i_nrst <= 1;
    @(posedge i_ref_clk);
    bus(5, 0, 32'h0000_0000);
    bus(2, 1, 32'h0000_002E);
    bus(2, 0, 32'h0000_002E);
    bus(0, 1, 32'h0000_0007);
    bus(0, 1, 32'h0000_0000);
    bus(0, 1, 32'h0000_0007);
    bus(0, 1, 32'h0000_0001);
    sense(8'h20, 8'h00);
    sense(8'h21, 8'h00);
    chk(u_dhpc_drive_model.pos[0], 0);
    $display("recalibrate done");
    t = 8'(6 + $urandom % 12);
    bus(0, 1, 32'h0000_000F);
    bus(0, 1, 32'h0000_0005);
    bus(0, 1, {24'h00_0000, t});
    bus(0, 1, 32'h0000_0007);
    bus(0, 1, 32'h0000_0002);
    bus(1, 0, 32'h0000_0086);
    wait_int();
    // Longest seek here is seventeen steps
    repeat (3000) @(posedge i_ref_clk);
    sense(8'h21, t);
    sense(8'h22, 8'h00);
    chk(u_dhpc_drive_model.pos[1], 32'(t));
    bus(0, 1, 32'h0000_000F);
    bus(0, 1, 32'h0000_0001);
    bus(0, 1, 32'h0000_0002);
    sense(8'h21, 8'h02);
    chk(u_dhpc_drive_model.pos[1], 2);
    bus(3, 0, 32'h0000_0200);
    $display("seek done");
    bus(0, 1, 32'h0000_0007);
    bus(0, 1, 32'h0000_0003);
    sense(8'h73, 8'h00);
    chk(u_dhpc_drive_model.pos[3], 45);
    bus(0, 1, 32'h0000_0007);
    bus(0, 1, 32'h0000_0003);
    sense(8'h23, 8'h00);
    chk(u_dhpc_drive_model.pos[3], 0);
    rdy <= 4'hE;
    repeat (4) @(posedge i_ref_clk);
    bus(0, 1, 32'h0000_000F);
    bus(0, 1, 32'h0000_0000);
    bus(0, 1, 32'h0000_0005);
    sense(8'h68, 8'h00);
    rdy <= 4'hF;
    bus(0, 1, 32'h0000_0008);
    bus(0, 0, 32'h0000_0080);
    $display("fault cases done");
    bus(0, 1, 32'h0000_004A);
    bus(0, 1, 32'h0000_0006);
    chk({29'h0000_0000, hsel, dsel}, 32'h0000_0006);
    idf <= dhpc_id_field_t'($urandom);
    idv <= 1;
    @(posedge i_ref_clk);
    idv <= 0;
    wait_int();
    bus(0, 0, 32'h0000_0006);
    bus(0, 0, 32'h0000_0000);
    bus(0, 0, 32'h0000_0000);
    bus(0, 0, {24'h00_0000, idf.cyl});
    bus(0, 0, {24'h00_0000, idf.head});
    bus(0, 0, {24'h00_0000, idf.sector});
    bus(0, 0, {24'h00_0000, idf.size});
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    bus(0, 1, 32'h0000_000A);
    bus(0, 1, 32'h0000_0000);
    pulse_idx();
    pulse_idx();
    wait_int();
    bus(0, 0, 32'h0000_0040);
    bus(0, 0, 32'h0000_0001);
    repeat (5) bus(0, 0, 32'h0000_0000);
    $display("identifier read done");
    preamble(8'h4E, 80, 12, 3, 32'h0000_006E);
    preamble(8'hFF, 40, 6, 0, 32'h0000_004E);
    $display("preamble done");
    bus(2, 1, 32'h0000_001E);
    bus(2, 1, 32'h0000_000E);
    bus(3, 0, 32'h0000_0000);
    $display("low power done");
    complete_run();
  end
endmodule
